// ### logic/spi_flags_pkg.sv
// Package of register map, field positions and carrier types for the status flag block
package spi_flags_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_CTRL   = 8'h08;
    localparam logic [7:0] OFS_FLOW   = 8'h0C;

    // Status and mask bit positions
    localparam int BIT_READY_EDGE  = 15;
    localparam int BIT_SELECT_FALL = 14;
    localparam int BIT_SELECT_RISE = 13;
    localparam int BIT_SELECT_ERR  = 12;
    localparam int BIT_SELECT_LVL  = 11;
    localparam int BIT_RX_OVERFLOW = 7;
    localparam int BIT_RX_COUNT    = 6;
    localparam int BIT_TX_COUNT    = 5;
    localparam int BIT_IRQ_SUMMARY = 0;

    // Write-one-to-clear bits, and those also cleared by unit disable
    localparam logic [15:0] W1C_BITS     = 16'hF0E0;
    localparam logic [15:0] DISABLE_BITS = 16'h70E0;

    // Reset values
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET  = 16'h0000;
    localparam logic [1:0]  MODE_RESET  = 2'h0;

    // Flow-control mode codes
    localparam logic [1:0] MODE_READY_PIN = 2'h2;
    localparam logic [1:0] MODE_DATA_PIN  = 2'h3;

    // Serial bits in one byte, minus one
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Control register layout, high bits first down to bit 0
    typedef struct packed {
        logic dma_mode;
        logic continuous_mode;
        logic slave_mode;
        logic transfer_initiate_mode;
        logic receive_flush;
        logic unit_enable;
    } ctrl_t;

    // Flow-control register layout
    typedef struct packed {
        logic       ready_polarity;
        logic [1:0] flow_control_mode;
    } flow_t;

    // Serial pins sampled by the peripheral clock
    typedef struct packed {
        logic select_n;
        logic sclk;
        logic ready;
        logic miso;
    } pins_t;

    localparam ctrl_t CTRL_RESET = '0;
    localparam flow_t FLOW_RESET = '0;
    localparam pins_t PINS_IDLE  = 4'hC;

    // Events from the shifter and FIFOs on the peripheral clock
    typedef struct packed {
        logic rx_load;
        logic rx_full;
        logic rx_count_done;
        logic tx_count_done;
    } unit_events_t;

endpackage

// ### logic/level_sync.sv
// Two-flop synchroniser for pin levels entering the peripheral clock domain
`timescale 1ns/10ps
module level_sync
    import spi_flags_pkg::*;
(
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Raw and synchronised pins
    input  wire pins_t d,
    output pins_t      q
);

    pins_t meta;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= PINS_IDLE;
            q    <= PINS_IDLE;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ### logic/spi_status_event_flags.sv
// Status and event flags of the serial unit, with APB registers and one interrupt
`timescale 1ns/10ps

// Behaviour
// RULE1: Mode 10: ready pin edge sets bit 15
// RULE2: Mode 11: data input edge sets bit 15
// RULE3: Other modes hold ready flag at zero
// RULE4: Ready polarity picks rising or falling edge
// RULE5: Ready flag interrupts if enabled; write-one clears
// RULE6: Continuous slave: select fall sets bit 14; the code sets it only while mask bit 14 is set
// RULE7: Continuous slave: select rise sets bit 13; the code sets it only while mask bit 14 is set
// RULE8: Slave select released mid-byte sets bit 12
// RULE9: Select flags cleared by one or disable
// RULE10: Bit 11 shows select level read-only
// RULE11: Select level synchronised before status bit
// RULE12: Load into full receive FIFO sets bit 7
// RULE13: Receive count reached, no DMA, mode 0
// RULE14: Transmit count reached, no DMA, mode 1
// RULE15: Bits 7,6,5 cleared by one or disable
// RULE16: Bit 0 high while any interrupt pending
// RULE17: Zero writes and read-only writes change nothing
module spi_status_event_flags
    import spi_flags_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Serial pins, asynchronous to pclk
    input  wire pins_t        pins,
    // Events from the rest of the unit
    input  wire unit_events_t events,
    // Interrupt
    output logic              irq
);

    // Register select for a given offset
    function automatic logic reg_sel(input logic [7:0] addr, input logic [7:0] ofs);
        reg_sel = (addr == ofs);
    endfunction

    // Active edge from a level and its previous value
    function automatic logic active_edge(input logic now, input logic prev, input logic pol);
        active_edge = pol ? (now & ~prev) : (~now & prev);
    endfunction

    pins_t        pins_s;
    pins_t        pins_prev;
    pins_t        next_pins_prev;
    logic [15:0]  flags;
    logic [15:0]  next_flags;
    logic [15:0]  mask;
    logic [15:0]  next_mask;
    ctrl_t        ctrl;
    ctrl_t        next_ctrl;
    flow_t        flow;
    flow_t        next_flow;
    logic [2:0]   bit_count;
    logic [2:0]   next_bit_count;
    logic [31:0]  next_prdata;
    logic [15:0]  status_word;
    logic [15:0]  w1c;
    logic         mapped;
    logic         wr_access;
    logic         ready_edge;
    logic         select_fall;
    logic         select_rise;
    logic         sclk_rise;
    logic         select_abort;
    logic         overflow_event;
    logic         rx_count_event;
    logic         tx_count_event;
    logic [15:0]  pending;

    // Pins cross into pclk through two flops
    level_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pins),
        .q       (pins_s)
    );

    // APB decode; zero wait states, so pready is always high
    always_comb
    begin
        mapped    = reg_sel(paddr, OFS_STATUS) || reg_sel(paddr, OFS_MASK)
                 || reg_sel(paddr, OFS_CTRL) || reg_sel(paddr, OFS_FLOW);
        pready    = 1'b1;
        pslverr   = psel && penable && !mapped;
        wr_access = psel && penable && pwrite && mapped;
    end

    // Edge detection on synchronised pins
    always_comb
    begin
        next_pins_prev = pins_s;
        select_fall    = pins_prev.select_n & ~pins_s.select_n;
        select_rise    = ~pins_prev.select_n & pins_s.select_n;
        sclk_rise      = pins_s.sclk & ~pins_prev.sclk;
        ready_edge     = 1'b0;
        if (flow.flow_control_mode == MODE_READY_PIN)
        begin
            ready_edge = active_edge(pins_s.ready, pins_prev.ready, flow.ready_polarity); // RULE1 RULE4
        end
        else if (flow.flow_control_mode == MODE_DATA_PIN)
        begin
            ready_edge = active_edge(pins_s.miso, pins_prev.miso, flow.ready_polarity); // RULE2 RULE4
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_prev <= PINS_IDLE;
        end
        else
        begin
            pins_prev <= next_pins_prev;
        end
    end

    // Serial bit counter within a frame; only sclk rising edges are counted
    always_comb
    begin
        next_bit_count = bit_count;
        if (pins_s.select_n)
        begin
            next_bit_count = 3'h0;
        end
        else if (sclk_rise)
        begin
            next_bit_count = (bit_count == BIT_LAST) ? 3'h0 : bit_count + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_count <= 3'h0;
        end
        else
        begin
            bit_count <= next_bit_count;
        end
    end

    // Flag events, all gated by the unit enable
    always_comb
    begin
        select_abort   = ctrl.unit_enable && ctrl.slave_mode && select_rise
                      && (bit_count != 3'h0); // RULE8
        overflow_event = ctrl.unit_enable && events.rx_load && events.rx_full; // RULE12
        rx_count_event = ctrl.unit_enable && !ctrl.dma_mode && !ctrl.transfer_initiate_mode
                      && events.rx_count_done; // RULE13
        tx_count_event = ctrl.unit_enable && !ctrl.dma_mode && ctrl.transfer_initiate_mode
                      && events.tx_count_done; // RULE14
        w1c            = (wr_access && reg_sel(paddr, OFS_STATUS)) ? (pwdata[15:0] & W1C_BITS)
                                                                   : 16'h0000; // RULE17
    end

    // Sticky flags; a set in the same cycle as its clear wins
    always_comb
    begin
        next_flags = flags & ~w1c; // RULE5 RULE9 RULE15
        if (!ctrl.unit_enable)
        begin
            next_flags = next_flags & ~DISABLE_BITS; // RULE9 RULE15
        end
        if (ready_edge)
        begin
            next_flags[BIT_READY_EDGE] = 1'b1; // RULE1 RULE2
        end
        if ((flow.flow_control_mode != MODE_READY_PIN) && (flow.flow_control_mode != MODE_DATA_PIN))
        begin
            next_flags[BIT_READY_EDGE] = 1'b0; // RULE3
        end
        if (ctrl.unit_enable && ctrl.slave_mode && ctrl.continuous_mode && mask[BIT_SELECT_FALL])
        begin
            next_flags[BIT_SELECT_FALL] = next_flags[BIT_SELECT_FALL] | select_fall; // RULE6
            next_flags[BIT_SELECT_RISE] = next_flags[BIT_SELECT_RISE] | select_rise; // RULE7
        end
        next_flags[BIT_SELECT_ERR]  = next_flags[BIT_SELECT_ERR] | select_abort; // RULE8
        next_flags[BIT_RX_OVERFLOW] = next_flags[BIT_RX_OVERFLOW] | overflow_event; // RULE12
        next_flags[BIT_RX_COUNT]    = next_flags[BIT_RX_COUNT] | rx_count_event; // RULE13
        next_flags[BIT_TX_COUNT]    = next_flags[BIT_TX_COUNT] | tx_count_event; // RULE14
        next_flags = next_flags & W1C_BITS;
    end

    // Control registers; read-only bits are never stored
    always_comb
    begin
        next_mask = mask;
        next_ctrl = ctrl;
        next_flow = flow;
        if (wr_access && reg_sel(paddr, OFS_MASK))
        begin
            next_mask = pwdata[15:0] & W1C_BITS;
        end
        if (wr_access && reg_sel(paddr, OFS_CTRL))
        begin
            next_ctrl = pwdata[5:0];
        end
        if (wr_access && reg_sel(paddr, OFS_FLOW))
        begin
            next_flow = pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags <= FLAGS_RESET;
            mask  <= MASK_RESET;
            ctrl  <= CTRL_RESET;
            flow  <= FLOW_RESET;
        end
        else
        begin
            flags <= next_flags;
            mask  <= next_mask;
            ctrl  <= next_ctrl;
            flow  <= next_flow;
        end
    end

    // Pending sources; overflow is silent while the receive FIFO flushes
    always_comb
    begin
        pending = flags & mask; // RULE5
        if (ctrl.receive_flush)
        begin
            pending[BIT_RX_OVERFLOW] = 1'b0; // RULE12
        end
        status_word                  = flags;
        status_word[BIT_SELECT_LVL]  = pins_s.select_n; // RULE10 RULE11
        status_word[BIT_IRQ_SUMMARY] = |pending; // RULE16
        irq                          = |pending;
    end

    // Read data captured in the setup cycle, so it is stable for the access
    always_comb
    begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite)
        begin
            next_prdata = 32'h0000_0000;
            if (reg_sel(paddr, OFS_STATUS))
            begin
                next_prdata = {16'h0000, status_word};
            end
            else if (reg_sel(paddr, OFS_MASK))
            begin
                next_prdata = {16'h0000, mask};
            end
            else if (reg_sel(paddr, OFS_CTRL))
            begin
                next_prdata = {26'h0, ctrl};
            end
            else if (reg_sel(paddr, OFS_FLOW))
            begin
                next_prdata = {29'h0, flow};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else
        begin
            prdata <= next_prdata;
        end
    end

    // Checks next to the logic
    logic mode_is_ready;
    logic mode_is_data;
    assign mode_is_ready = (flow.flow_control_mode == MODE_READY_PIN);
    assign mode_is_data  = (flow.flow_control_mode == MODE_DATA_PIN);

    sequence s_ready_pin_edge;
        mode_is_ready && (flow.ready_polarity ? $rose(pins_s.ready) : $fell(pins_s.ready));
    endsequence

    sequence s_data_pin_edge;
        mode_is_data && (flow.ready_polarity ? $rose(pins_s.miso) : $fell(pins_s.miso));
    endsequence

    sequence s_pin_steady;
        (pins.select_n == $past(pins.select_n, 1)) && (pins.select_n == $past(pins.select_n, 2));
    endsequence

    a_ready_pin_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        s_ready_pin_edge |=> flags[BIT_READY_EDGE])
        else $error("ready edge flag not set in ready-pin mode");

    a_data_pin_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        s_data_pin_edge |=> flags[BIT_READY_EDGE])
        else $error("ready edge flag not set in data-pin mode");

    a_ready_mode_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        (!mode_is_ready && !mode_is_data) |=> !flags[BIT_READY_EDGE])
        else $error("ready edge flag set in other mode");

    a_ready_wrong_edge: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        (mode_is_ready && !flags[BIT_READY_EDGE] && (flow.ready_polarity ? !$rose(pins_s.ready)
        : !$fell(pins_s.ready))) |=> !flags[BIT_READY_EDGE])
        else $error("ready edge flag set without active edge");

    a_ready_clear_only: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        $fell(flags[BIT_READY_EDGE]) |-> ($past(w1c[BIT_READY_EDGE]) || $past(!mode_is_ready
            && !mode_is_data)))
        else $error("ready edge flag cleared without cause");

    a_select_fall_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        (ctrl.unit_enable && ctrl.slave_mode && ctrl.continuous_mode && mask[BIT_SELECT_FALL]
            && $fell(pins_s.select_n)) |=> flags[BIT_SELECT_FALL] && irq)
        else $error("select fall flag or interrupt missing");

    a_select_rise_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        (ctrl.unit_enable && ctrl.slave_mode && ctrl.continuous_mode && mask[BIT_SELECT_FALL]
            && $rose(pins_s.select_n)) |=> flags[BIT_SELECT_RISE])
        else $error("select rise flag missing");

    a_select_abort: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (ctrl.unit_enable && ctrl.slave_mode && $rose(pins_s.select_n) && bit_count != 3'h0)
        |=> flags[BIT_SELECT_ERR])
        else $error("select abort error not flagged");

    a_disable_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE9 RULE15
        !ctrl.unit_enable |=> (flags & DISABLE_BITS) == 16'h0000)
        else $error("flags survive unit disable");

    a_select_level: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        psel && !penable && !pwrite && reg_sel(paddr, OFS_STATUS)
        |=> prdata[BIT_SELECT_LVL] == $past(pins_s.select_n))
        else $error("select level bit wrong");

    a_select_sync: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        s_pin_steady |-> pins_s.select_n == $past(pins.select_n, 2))
        else $error("select level not synchronised in two cycles");

    a_overflow_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        (ctrl.unit_enable && events.rx_load && events.rx_full) |=> flags[BIT_RX_OVERFLOW]
            && (irq || !mask[BIT_RX_OVERFLOW] || ctrl.receive_flush))
        else $error("receive overflow not flagged");

    a_rx_count_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        (ctrl.unit_enable && !ctrl.dma_mode && !ctrl.transfer_initiate_mode
            && events.rx_count_done) |=> flags[BIT_RX_COUNT])
        else $error("receive count flag missing");

    a_tx_count_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        (ctrl.unit_enable && !ctrl.dma_mode && ctrl.transfer_initiate_mode
            && events.tx_count_done) |=> flags[BIT_TX_COUNT])
        else $error("transmit count flag missing");

    a_irq_summary: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
        status_word[BIT_IRQ_SUMMARY] == irq && (irq == ((flags & mask) != 16'h0000)
            || ctrl.receive_flush))
        else $error("summary bit disagrees with pending sources");

    a_zero_write_keep: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        (wr_access && reg_sel(paddr, OFS_STATUS) && pwdata[15:0] == 16'h0000 && ctrl.unit_enable
            && (mode_is_ready || mode_is_data)) |=> (flags & $past(flags)) == $past(flags))
        else $error("zero write changed a flag");

endmodule

// ### verif/serial_peer_model.sv
// External serial device model driving select, clock, ready and data pins
`timescale 1ns/10ps
module serial_peer_model
    import spi_flags_pkg::*;
(
    // Pins towards the unit
    output pins_t pins
);
    // Select and clock idle high; clock stands still outside frames
    initial pins = PINS_IDLE;

    // One level change on ready (which=0) or data (which=1), then hold
    task automatic level(input logic which, input logic v);
        if (which)
            pins.miso = v;
        else
            pins.ready = v;
        #300;
    endtask

    // Master frame of n clock pulses, 200 ns clock period
    task automatic frame(input int nbits);
        pins.select_n = 1'b0;
        #300;
        repeat (nbits)
        begin
            pins.sclk = 1'b0;
            pins.miso = ~pins.miso;
            #100;
            pins.sclk = 1'b1;
            #100;
        end
        #200;
        pins.select_n = 1'b1;
        #100;
        // Released data line must not keep its last value
        pins.miso = ~pins.miso;
    endtask
endmodule

// ### verif/spi_status_event_flags_tb.sv
// Self-checking bench of the status flag block over APB
`timescale 1ns/10ps
module spi_status_event_flags_tb
    import spi_flags_pkg::*;
;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    pins_t        pins;
    unit_events_t events;
    logic         irq;
    int           bad_count;
    int           checked;
    logic [31:0]  rnd;
    logic [15:0]  mask_v;
    logic         flush_v;
    logic [31:0]  r;
    logic         e;

    spi_status_event_flags i_dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .pins    (pins),
        .events  (events),
        .irq     (irq)
    );

    serial_peer_model i_peer (
        .pins (pins)
    );

    // 40 MHz clock
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    // Pseudo-random source, fixed start value
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected interrupt level; overflow is ignored while flushing
    function automatic logic exp_irq(input logic [15:0] f);
        logic [15:0] m;
        m = mask_v & W1C_BITS & ~(flush_v ? 16'h0080 : 16'h0000);
        return |(f & m);
    endfunction

    // Expected ready-edge flag for one pin change
    function automatic logic [15:0] exp_rdy(input int m, p, v, input logic [1:0] code);
        return (m == code && p == v) ? 16'h8000 : 16'h0000;
    endfunction

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            bad_count++;
    endtask

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1)
        begin
            bad_count++;
            end_sim();
        end
        else
        begin
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            // One idle edge, so a following call never re-raises psel in this step
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Status read compared with flags, select level, summary and irq pin
    task automatic stat(input logic [15:0] f, input logic s);
        logic q;
        q = exp_irq(f);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, e}, 32'h0);
        chk(r, {16'h0, f | ({15'h0, s} << BIT_SELECT_LVL) | {15'h0, q}});
        chk({31'h0, irq}, {31'h0, q});
    endtask

    task automatic ctl(input ctrl_t c);
        flush_v = c.receive_flush;
        wr(OFS_CTRL, {26'h0, c});
    endtask

    task automatic ev(input unit_events_t x);
        events <= x;
        @(posedge pclk);
        events <= '0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        events = '0;
        bad_count = 0;
        checked = 0;
        rnd = 32'h821B;
        mask_v = 16'h0;
        flush_v = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        // Reset values; select idles high
        stat(16'h0000, 1'b1);
        apb(1'b0, OFS_MASK, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, OFS_FLOW, 32'h0);
        chk(r, 32'h0);
        // Unmapped place answers with an error and zero
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        mask_v = W1C_BITS;
        wr(OFS_MASK, {16'h0, mask_v});
        ctl(6'h01);
        // Every mode and polarity, each pin moved up then down
        for (int m = 0; m < 4; m++)
            for (int p = 0; p < 2; p++)
            begin
                wr(OFS_FLOW, {29'h0, p[0], m[1:0]});
                for (int v = 1; v >= 0; v--)
                begin
                    i_peer.level(1'b0, v[0]);
                    settle();
                    wr(OFS_STATUS, 32'h0);
                    stat(exp_rdy(m, p, v, MODE_READY_PIN), 1'b1);
                    wr(OFS_STATUS, 32'h8000);
                    i_peer.level(1'b1, v[0]);
                    settle();
                    stat(exp_rdy(m, p, v, MODE_DATA_PIN), 1'b1);
                    wr(OFS_STATUS, 32'h8000);
                end
            end
        wr(OFS_FLOW, 32'h0);
        // Continuous slave frames: whole byte, then an early release
        ctl(6'h19);
        fork
            i_peer.frame(8);
            begin
                repeat (30) @(posedge pclk);
                stat(16'h4000, 1'b0);
            end
        join
        settle();
        stat(16'h6000, 1'b1);
        wr(OFS_STATUS, 32'h0801);
        stat(16'h6000, 1'b1);
        wr(OFS_STATUS, 32'h6000);
        stat(16'h0000, 1'b1);
        rnd = lfsr(rnd);
        i_peer.frame(1 + rnd % 7);
        settle();
        stat(16'h7000, 1'b1);
        ctl(6'h18);
        stat(16'h0000, 1'b1);
        // Plain slave: only the abort flag, no select edge flags
        ctl(6'h09);
        i_peer.frame(3);
        settle();
        stat(16'h1000, 1'b1);
        wr(OFS_STATUS, 32'h1000);
        // Unit events under a random mask
        rnd = lfsr(rnd);
        mask_v = rnd[15:0] & W1C_BITS;
        wr(OFS_MASK, {16'h0, mask_v});
        apb(1'b0, OFS_MASK, 32'h0);
        chk(r, {16'h0, mask_v});
        ctl(6'h01);
        ev(4'h8);
        stat(16'h0000, 1'b1);
        ev(4'hC);
        stat(16'h0080, 1'b1);
        ev(4'h2);
        stat(16'h00C0, 1'b1);
        ev(4'h1);
        stat(16'h00C0, 1'b1);
        ctl(6'h05);
        wr(OFS_STATUS, 32'h0040);
        ev(4'h3);
        stat(16'h00A0, 1'b1);
        ctl(6'h07);
        stat(16'h00A0, 1'b1);
        ctl(6'h25);
        wr(OFS_STATUS, 32'hFFFF);
        ev(4'h3);
        stat(16'h0000, 1'b1);
        ctl(6'h05);
        ev(4'hD);
        stat(16'h00A0, 1'b1);
        ctl(6'h04);
        stat(16'h0000, 1'b1);
        end_sim();
    end
endmodule
